// File: nvu_regs.vh
// Register offsets, field positions, reset values and line maps of the interrupt unit.
`ifndef NVU_REGS_VH
`define NVU_REGS_VH
`define NVU_SETEN 12'h000
`define NVU_CLREN 12'h004
`define NVU_SETPEND 12'h008
`define NVU_CLRPEND 12'h00c
`define NVU_PRIO0 12'h010
`define NVU_PRIO7 12'h02c
`define NVU_SYSPRI 12'h030
`define NVU_STAT 12'h034
`define NVU_PRIO_MSB 7
`define NVU_PRIO_RST 2'h0
`define NVU_RANK_NMI 3'h1
`define NVU_RANK_HF 3'h2
`define NVU_RANK_CFG 3'h3
`define NVU_RANK_NONE 3'h7
`define NVU_VEC_NMI 6'h02
`define NVU_VEC_HF 6'h03
`define NVU_VEC_SVC 6'h0b
`define NVU_VEC_PSV 6'h0e
`define NVU_VEC_TICK 6'h0f
`define NVU_VEC_IRQ0 6'h10
`define NVU_VEC_BASE 32'h0000_0000
`define NVU_SP_WORD 32'h0000_0000
`define NVU_PC_WORD 32'h0000_0004
`define NVU_LINES_BIG 32'h360c_ffff
`define NVU_WAKE_BIG 32'h160c_3f3f
`define NVU_LINES_SMALL 32'h3207_53f7
`define NVU_WAKE_SMALL 32'h1205_1337
`define NVU_HIGH_PORTS_BIG 24'hfff3ff
`define NVU_HIGH_PORTS_SMALL 24'hfffbff
`endif

// File: nvu_src_map.v
// Maps peripheral and pin requests onto the 32 interrupt lines and their wake-up mask.
`timescale 1ns/10ps
`default_nettype none
`include "nvu_regs.vh"
module nvu_src_map #(
  parameter SMALL_VARIANT = 0
) (
  input wire ext_pin_irq_a,
  input wire ext_pin_irq_b,
  input wire [15:0] port_group_low_irq,
  input wire [23:0] port_group_high_irq,
  input wire [31:0] periph_irq,
  output wire [31:0] irq_lines,
  output wire [31:0] wake_mask
);
  wire [31:0] impl_mask;
  wire [23:0] high_mask;
  wire [31:0] raw;

  assign impl_mask = SMALL_VARIANT ? `NVU_LINES_SMALL : `NVU_LINES_BIG;
  assign high_mask = SMALL_VARIANT ? `NVU_HIGH_PORTS_SMALL : `NVU_HIGH_PORTS_BIG;
  // Wide port group bits 10 and 11 (bit 10 only in the small variant, which drops line 3) are masked so the pins never raise two lines.
  assign raw = {periph_irq[31:6], |(port_group_high_irq & high_mask),
    |port_group_low_irq, ext_pin_irq_b, ext_pin_irq_a, periph_irq[1:0]};
  assign irq_lines = raw & impl_mask;
  assign wake_mask = SMALL_VARIANT ? `NVU_WAKE_SMALL : `NVU_WAKE_BIG;
endmodule
`default_nettype wire

// File: nvu_irq_ctrl.v
// Nested vectored interrupt unit with APB registers and a core vector-fetch port.
// Overview of operation
// - Four configurable levels, zero most urgent.
// - All configurable priorities reset to zero.
// - Reset, NMI, hard fault outrank configurable.
// - Line N is vector N plus sixteen.
// - Vector table base fixed at zero.
// - Word zero holds initial main stack pointer.
// - Write-one set and clear enable views.
// - Disabled lines pend but never activate, except one disabled while the core acknowledges its entry.
// - Disabling leaves an active interrupt active.
// - Write-one set and clear pending views.
// - Clearing pending never touches active state.
// - Priority in 8-bit fields, four per word.
// - Line 28 wake request wakes the chip.
// - Only listed peripheral lines may wake.
// - Pins and port groups feed lines 2-5; the small variant masks off line 3.
// - Small variant lines 16 and 17.
// - More urgent request preempts running handler.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "nvu_regs.vh"
module nvu_irq_ctrl #(
  parameter SMALL_VARIANT = 0
) (
  input wire core_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire nmi_in,
  input wire hardfault_in,
  input wire supervisor_call_exception,
  input wire pendable_service_exception,
  input wire system_tick_exception,
  input wire ext_pin_irq_a,
  input wire ext_pin_irq_b,
  input wire [15:0] port_group_low_irq,
  input wire [23:0] port_group_high_irq,
  input wire [31:0] periph_irq,
  input wire core_ack,
  input wire exc_return,
  output reg fetch_req,
  output reg [31:0] fetch_addr,
  output reg [5:0] fetch_vec,
  output reg wake_req
);
  localparam [3:0] ST_BOOT_SP = 4'b0001;
  localparam [3:0] ST_BOOT_PC = 4'b0010;
  localparam [3:0] ST_IDLE = 4'b0100;
  localparam [3:0] ST_ENTRY = 4'b1000;

  reg [3:0] state_q;
  reg [31:0] en_q;
  reg [36:0] pend_q;
  reg [36:0] pend_d;
  reg [36:0] act_q;
  reg [36:0] act_d;
  reg [63:0] prio_q;
  reg [5:0] sys_prio_q;
  wire [31:0] irq_lines;
  wire [31:0] wake_mask;
  wire [36:0] hw_set;
  wire wr_acc;
  wire [2:0] prio_idx;
  wire [69:0] prio_all;
  reg [5:0] best_k;
  reg [2:0] best_r;
  reg [5:0] cur_k;
  reg [2:0] cur_r;
  reg best_ok;
  reg [31:0] rd_d;
  reg map_d;
  reg [5:0] entry_k_q;
  reg [2:0] k_r;
  integer k;

  nvu_src_map #(
    .SMALL_VARIANT(SMALL_VARIANT)
  ) u_map (
    .ext_pin_irq_a(ext_pin_irq_a),
    .ext_pin_irq_b(ext_pin_irq_b),
    .port_group_low_irq(port_group_low_irq),
    .port_group_high_irq(port_group_high_irq),
    .periph_irq(periph_irq),
    .irq_lines(irq_lines),
    .wake_mask(wake_mask)
  );

  // Slot 0..4 are the system exceptions, slots 5..36 the peripheral lines.
  function [5:0] vec_of;
    input [5:0] s;
    begin
      case (s)
        6'd0: vec_of = `NVU_VEC_NMI;
        6'd1: vec_of = `NVU_VEC_HF;
        6'd2: vec_of = `NVU_VEC_SVC;
        6'd3: vec_of = `NVU_VEC_PSV;
        6'd4: vec_of = `NVU_VEC_TICK;
        default: vec_of = s - 6'd5 + `NVU_VEC_IRQ0;
      endcase
    end
  endfunction

  // Rank 1 and 2 are the fixed levels, configurable level p becomes rank p + 3.
  // Priorities come in as an argument so that a priority write alone re-runs arbitration.
  function [2:0] rank_of;
    input [5:0] s;
    input [69:0] pa;
    begin
      case (s)
        6'd0: rank_of = `NVU_RANK_NMI;
        6'd1: rank_of = `NVU_RANK_HF;
        6'd2: rank_of = `NVU_RANK_CFG + {1'b0, pa[1:0]};
        6'd3: rank_of = `NVU_RANK_CFG + {1'b0, pa[3:2]};
        6'd4: rank_of = `NVU_RANK_CFG + {1'b0, pa[5:4]};
        default: rank_of = `NVU_RANK_CFG + {1'b0, pa[6 + 2 * (s - 6'd5) +: 2]};
      endcase
    end
  endfunction

  // Only the two most significant bits of each byte field are implemented.
  function [7:0] field;
    input [1:0] p;
    begin
      field = {p, 6'h00};
    end
  endfunction

  assign hw_set = {irq_lines, system_tick_exception, pendable_service_exception,
    supervisor_call_exception, hardfault_in, nmi_in};
  assign wr_acc = psel & penable & pready & pwrite;
  assign prio_idx = paddr[4:2] - 3'd4;
  assign prio_all = {prio_q, sys_prio_q};

  // Strict compare on an ascending scan keeps the lowest vector among equals.
  always @* begin
    best_k = 6'd0;
    best_r = `NVU_RANK_NONE;
    best_ok = 1'b0;
    cur_k = 6'd0;
    cur_r = `NVU_RANK_NONE;
    k_r = `NVU_RANK_NONE;
    for (k = 0; k < 37; k = k + 1) begin
      k_r = rank_of(k[5:0], prio_all);
      if (pend_q[k] && (k < 5 || en_q[k - 5]) && k_r < best_r) begin
        best_k = k[5:0];
        best_r = k_r;
        best_ok = 1'b1;
      end
      if (act_q[k] && k_r < cur_r) begin
        cur_k = k[5:0];
        cur_r = k_r;
      end
    end
  end

  // Hardware set wins over a software or entry clear in the same cycle.
  always @* begin
    pend_d = pend_q | hw_set;
    act_d = act_q;
    // The slot offered to the core is the one made active, even if arbitration moved on.
    if (state_q == ST_ENTRY && core_ack) begin
      pend_d[entry_k_q] = hw_set[entry_k_q];
      act_d[entry_k_q] = 1'b1;
    end
    if (wr_acc && paddr == `NVU_SETPEND) begin
      pend_d[36:5] = pend_d[36:5] | pwdata;
    end
    if (wr_acc && paddr == `NVU_CLRPEND) begin
      pend_d[36:5] = pend_d[36:5] & ~(pwdata & ~hw_set[36:5]);
    end
    if (exc_return && cur_r != `NVU_RANK_NONE) begin
      act_d[cur_k] = 1'b0;
    end
  end

  always @* begin
    map_d = 1'b1;
    rd_d = 32'h0000_0000;
    case (paddr)
      `NVU_SETEN, `NVU_CLREN: rd_d = en_q;
      `NVU_SETPEND, `NVU_CLRPEND: rd_d = pend_q[36:5];
      `NVU_SYSPRI: rd_d = {8'h00, field(sys_prio_q[5:4]), field(sys_prio_q[3:2]),
        field(sys_prio_q[1:0])};
      `NVU_STAT: rd_d = {13'h0000, cur_r, 2'b00, (best_ok ? vec_of(best_k) : 6'h00), 2'b00,
        (cur_r == `NVU_RANK_NONE) ? 6'h00 : vec_of(cur_k)};
      default: begin
        if (paddr >= `NVU_PRIO0 && paddr <= `NVU_PRIO7 && paddr[1:0] == 2'b00) begin
          rd_d = {field(prio_q[8 * prio_idx + 6 +: 2]), field(prio_q[8 * prio_idx + 4 +: 2]),
            field(prio_q[8 * prio_idx + 2 +: 2]), field(prio_q[8 * prio_idx +: 2])};
        end else begin
          map_d = 1'b0;
        end
      end
    endcase
  end

  // Registering at setup lets read data and the error flag come from flops with no wait state.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      if (psel & ~penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_d;
        pslverr <= ~map_d;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      en_q <= 32'h0000_0000;
      prio_q <= 64'h0000_0000_0000_0000;
      sys_prio_q <= {3{`NVU_PRIO_RST}};
    end else if (wr_acc) begin
      if (paddr == `NVU_SETEN) begin
        en_q <= en_q | pwdata;
      end
      if (paddr == `NVU_CLREN) begin
        en_q <= en_q & ~pwdata;
      end
      if (paddr == `NVU_SYSPRI) begin
        sys_prio_q <= {pwdata[23:22], pwdata[15:14], pwdata[7:6]};
      end
      if (paddr >= `NVU_PRIO0 && paddr <= `NVU_PRIO7 && paddr[1:0] == 2'b00) begin
        prio_q[8 * prio_idx +: 8] <= {pwdata[31:30], pwdata[23:22],
          pwdata[15:14], pwdata[7:6]};
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_q <= 37'h00_0000_0000;
      act_q <= 37'h00_0000_0000;
      wake_req <= 1'b0;
    end else begin
      pend_q <= pend_d;
      act_q <= act_d;
      wake_req <= |(pend_d[36:5] & wake_mask);
    end
  end

  // Boot fetches the stack pointer and reset entry, then entries follow arbitration.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_BOOT_SP;
      fetch_req <= 1'b1;
      fetch_addr <= `NVU_SP_WORD;
      fetch_vec <= 6'h00;
      entry_k_q <= 6'h00;
    end else begin
      case (state_q)
        ST_BOOT_SP: begin
          if (core_ack) begin
            state_q <= ST_BOOT_PC;
            fetch_addr <= `NVU_VEC_BASE + `NVU_PC_WORD;
            fetch_vec <= 6'h01;
          end
        end
        ST_BOOT_PC: begin
          if (core_ack) begin
            state_q <= ST_IDLE;
            fetch_req <= 1'b0;
          end
        end
        ST_IDLE: begin
          if (best_ok && best_r < cur_r) begin
            state_q <= ST_ENTRY;
            fetch_req <= 1'b1;
            entry_k_q <= best_k;
            fetch_vec <= vec_of(best_k);
            fetch_addr <= `NVU_VEC_BASE + {24'h00_0000, vec_of(best_k), 2'b00};
          end
        end
        ST_ENTRY: begin
          if (core_ack) begin
            state_q <= ST_IDLE;
            fetch_req <= 1'b0;
          end else if (!best_ok || best_r >= cur_r) begin
            state_q <= ST_IDLE;
            fetch_req <= 1'b0;
          end else begin
            // A later, more urgent request retargets the entry before it is taken.
            entry_k_q <= best_k;
            fetch_vec <= vec_of(best_k);
            fetch_addr <= `NVU_VEC_BASE + {24'h00_0000, vec_of(best_k), 2'b00};
          end
        end
        default: begin
          state_q <= ST_IDLE;
          fetch_req <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: nvu_irq_ctrl_monitor.sv
// Concurrent checks on the bus and fetch ports of the interrupt unit.
`timescale 1ns/10ps
`default_nettype none
module nvu_irq_ctrl_monitor (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] periph_irq,
  input wire logic core_ack,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic [5:0] fetch_vec,
  input wire logic wake_req
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_boot_ack;
    fetch_req && core_ack && fetch_vec == 6'h00;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (pready && (paddr > 12'h034 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && paddr <= 12'h034 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_err_data_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused access returned data");
  a_fetch_addr: assert property (fetch_req |-> fetch_addr == {24'h0, fetch_vec, 2'h0})
    else $error("fetch address not vector times four");
  a_boot_order: assert property (s_boot_ack |=> fetch_req && fetch_addr == 32'h4)
    else $error("stack word not followed by reset vector");
  a_wake_line28: assert property ($rose(periph_irq[28]) |-> ##[1:2] wake_req)
    else $error("wake line gave no wake request");
endmodule
bind nvu_irq_ctrl nvu_irq_ctrl_monitor nvu_irq_ctrl_monitor_inst (.core_clk, .rst, .psel,
  .penable, .paddr, .prdata, .pready, .pslverr, .periph_irq, .core_ack, .fetch_req,
  .fetch_addr, .fetch_vec, .wake_req);
`default_nettype wire

// File: nvu_core_model.sv
// Behavioural processor core that accepts offered vector fetches after a chosen delay.
`timescale 1ns/10ps
`default_nettype none
module nvu_core_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic fetch_req,
  input wire logic [5:0] fetch_vec,
  input wire logic [1:0] delay,
  output var logic core_ack,
  output var logic [5:0] taken_vec,
  output var int n_taken
);
  logic [1:0] wait_q;
  // A slow core lets the offer stand, so a late more urgent request can replace it.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      core_ack <= 1'b0;
      wait_q <= 2'h0;
      taken_vec <= 6'h00;
      n_taken <= 0;
    end else begin
      if (fetch_req && core_ack) begin
        taken_vec <= fetch_vec;
        n_taken <= n_taken + 1;
      end
      core_ack <= fetch_req && !core_ack && wait_q == delay;
      wait_q <= (fetch_req && !core_ack && wait_q != delay) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// File: nested_vectored_irq_ctrl_test.sv
// Self-checking bench for the interrupt unit with a behavioural core.
`timescale 1ns/10ps
`default_nettype none
`include "nvu_regs.vh"
module nested_vectored_irq_ctrl_test;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, core_ack, exc_return;
  logic nmi_in, hardfault_in, supervisor_call_exception, pendable_service_exception;
  logic system_tick_exception, ext_pin_irq_a, ext_pin_irq_b, fetch_req, wake_req, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, periph_irq, fetch_addr, rd_q, r, m;
  logic [15:0] port_group_low_irq;
  logic [23:0] port_group_high_irq;
  logic [5:0] fetch_vec, taken_vec;
  logic [1:0] delay;
  int n_taken, n_mismatch, n_tests, cyc, k, n;
  nvu_irq_ctrl nvu_irq_ctrl_inst (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .nmi_in, .hardfault_in, .supervisor_call_exception,
    .pendable_service_exception, .system_tick_exception, .ext_pin_irq_a, .ext_pin_irq_b,
    .port_group_low_irq, .port_group_high_irq, .periph_irq, .core_ack, .exc_return,
    .fetch_req, .fetch_addr, .fetch_vec, .wake_req);
  nvu_core_model nvu_core_model_inst (.core_clk, .rst, .fetch_req, .fetch_vec, .delay,
    .core_ack, .taken_vec, .n_taken);
  always #20 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bus cycle: setup, then access held until ready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Ready is sampled at the rising edge at which the write lands and read data stands.
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask
  task automatic take(input logic [5:0] v);
    int n0;
    n0 = n_taken;
    // A fetch that never comes is caught by the bench timeout.
    while (n_taken == n0) begin
      @(posedge core_clk);
    end
    chk({26'h0, taken_vec}, {26'h0, v});
  endtask
  task automatic ret;
    exc_return <= 1'b1;
    @(posedge core_clk);
    exc_return <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic pulse_src(input logic [31:0] p, input logic a, input logic [15:0] l);
    periph_irq <= p;
    ext_pin_irq_a <= a;
    port_group_low_irq <= l;
    @(posedge core_clk);
    periph_irq <= 32'h0;
    ext_pin_irq_a <= 1'b0;
    port_group_low_irq <= 16'h0;
    repeat (2) @(posedge core_clk);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict;
    end
  end
  initial begin
    {core_clk, psel, penable, pwrite, nmi_in, hardfault_in, exc_return} = 7'h0;
    {supervisor_call_exception, pendable_service_exception, system_tick_exception} = 3'h0;
    {ext_pin_irq_a, ext_pin_irq_b, port_group_low_irq, port_group_high_irq} = 42'h0;
    {paddr, pwdata, periph_irq, delay, n_mismatch, n_tests, cyc} = 'h0;
    rst = 1'b1;
    void'($urandom(51));
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    take(6'h00);
    take(6'h01);
    for (k = 0; k < 9; k++) rd(12'h010 + 12'(k * 4), 32'h0);
    rd(12'h040, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    r = $urandom;
    m = $urandom;
    apb(1'b1, `NVU_SETEN, r);
    apb(1'b1, `NVU_SETEN, 32'h0);
    rd(`NVU_CLREN, r);
    apb(1'b1, `NVU_CLREN, m);
    rd(`NVU_SETEN, r & ~m);
    apb(1'b1, `NVU_CLREN, 32'hffff_ffff);
    pulse_src(32'h1, 1'b1, 16'h0008);
    rd(`NVU_SETPEND, 32'h15);
    chk(32'(n_taken), 32'h2);
    apb(1'b1, `NVU_CLRPEND, 32'hffff_ffff);
    rd(`NVU_SETPEND, 32'h0);
    pulse_src(32'h1000_0000, 1'b0, 16'h0);
    chk({31'h0, wake_req}, 32'h1);
    apb(1'b1, `NVU_CLRPEND, 32'hffff_ffff);
    pulse_src(32'h40, 1'b0, 16'h0);
    chk({31'h0, wake_req}, 32'h0);
    apb(1'b1, `NVU_CLRPEND, 32'hffff_ffff);
    nmi_in <= 1'b1;
    @(posedge core_clk);
    nmi_in <= 1'b0;
    take(`NVU_VEC_NMI);
    ret;
    apb(1'b1, `NVU_SYSPRI, 32'h00c0_4000);
    rd(`NVU_SYSPRI, 32'h00c0_4000);
    {hardfault_in, supervisor_call_exception, pendable_service_exception,
      system_tick_exception} <= 4'hf;
    @(posedge core_clk);
    {hardfault_in, supervisor_call_exception, pendable_service_exception,
      system_tick_exception} <= 4'h0;
    take(`NVU_VEC_HF);
    ret;
    take(`NVU_VEC_SVC);
    ret;
    take(`NVU_VEC_PSV);
    ret;
    take(`NVU_VEC_TICK);
    ret;
    apb(1'b1, `NVU_SYSPRI, 32'h0);
    apb(1'b1, `NVU_SETEN, 32'h300);
    apb(1'b1, `NVU_SETPEND, 32'h300);
    take(6'h18);
    ret;
    take(6'h19);
    ret;
    apb(1'b1, `NVU_CLREN, 32'hffff_ffff);
    apb(1'b1, `NVU_PRIO0, 32'hffff_ffff);
    rd(`NVU_PRIO0, 32'hc0c0_c0c0);
    apb(1'b1, `NVU_PRIO0, 32'h0000_00c0);
    apb(1'b1, `NVU_SETEN, 32'h3);
    apb(1'b1, `NVU_SETPEND, 32'h1);
    take(6'h10);
    apb(1'b1, `NVU_SETPEND, 32'h2);
    take(6'h11);
    apb(1'b1, `NVU_CLREN, 32'h3);
    ret;
    apb(1'b1, `NVU_CLRPEND, 32'h1);
    rd(`NVU_STAT, 32'h0006_0010);
    ret;
    apb(1'b1, `NVU_PRIO0, 32'h0);
    // Random lines, reserved ones too, since software pending still reaches them.
    for (k = 0; k < 6; k++) begin
      n = $urandom_range(31, 0);
      delay <= 2'($urandom);
      apb(1'b1, `NVU_SETEN, 32'h1 << n);
      apb(1'b1, `NVU_SETPEND, 32'h1 << n);
      take(6'(n + 16));
      ret;
      apb(1'b1, `NVU_CLREN, 32'hffff_ffff);
    end
    print_verdict;
  end
endmodule
`default_nettype wire
